// [bcv_regs.v]
// Purpose: board controller bank: lamps, volume, serial eeprom window, reset domains
// Assumes: AHB-Lite single word transfers, one slave, synchronous inputs
// Notes: every access inserts wait states; eeprom window waits longer
//   all outputs come straight from flip-flops
//   window writes need the eeprom enable bit set
//   hsize is not checked, word access assumed
`timescale 1ns/1ns
`include "bcv_consts.vh"

// Behaviour
// - eeprom enable bit resets to 0; writing 1 enables eeprom access.
// - each window byte location maps one-to-one to an eeprom byte from 0x0100.
// - window bytes are read/write, content after reset is undefined.
// - volume registers take any byte, 0x00 quietest, 0xff loudest, reset 0x00.
// - right volume at 0x00d0, left volume at 0x00d1, independent read/write.
// - lamp register at 0x00a0, bit n drives lamp n+1, 1 lights it.
// - power-up or hard reset switch restores every register, counters too.
// - soft reset keeps rtc state; control, lamp, volume, eeprom registers reinit.
// - reset switch with switch soft reset enable bit clear holds all registers; counters keep running.
// - power bit written 0 zeroes power, lamp, front light; others reinit or hold.
// - time counters clear only on power-up or hard reset.
// - eeprom control at 0x00c0, enable in bit 0, other bits read zero.
// - eeprom holds 128 bytes readable and writable through the window.
module bcv_regs #(
  parameter EE_DEPTH = 128,
  parameter EE_WAIT = `BCV_EE_WAIT
) (
  input wire sys_clk,
  input wire srst,
  // bus slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // reset sources and time base
  input wire hard_reset_switch,
  input wire reset_switch,
  input wire sec_tick,
  // register outputs
  output reg [7:0] lamp_control,
  output reg [7:0] volume_right,
  output reg [7:0] volume_left,
  output reg [7:0] front_light_reg,
  output reg [7:0] system_power_ctrl_one,
  output reg [7:0] eeprom_ctrl_reg
);

  // ==========================================
  // state and storage
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_BUSY = 2'b10;
  localparam [7:0] ONE_WAIT = 8'h01;
  // st_q one-hot: idle waits for an address phase,
  // busy counts cnt_q down to one and then answers

  // one-hot bus state
  reg [1:0] st_q;
  // word index of the pending transfer
  reg [9:0] idx_q;
  // pending transfer is a write
  reg wr_q;
  // wait cycles left before the answer
  reg [7:0] cnt_q;
  // soft reset strobe, switch soft reset enable, select bit
  reg [7:0] reset_ctrl_reg;
  // free-running seconds, cleared only by power-up class resets
  reg [7:0] seconds_counter;
  // status kept through soft reset and power off
  reg [7:0] rtc_state_reg;
  // eeprom image, one byte per window location
  reg [7:0] ee_mem [0:EE_DEPTH-1];

  // ==========================================
  // decode helpers
  // indices backed by eeprom storage
  // used by the read mux, the array write and the wait count
  function in_window;
    input [9:0] idx;
    begin
      in_window = (idx >= `BCV_IDX_WIN_BASE) &&
                  (idx < `BCV_IDX_WIN_BASE + EE_DEPTH[9:0]);
    end
  endfunction

  // anywhere in the printed window span
  function in_span;
    input [9:0] idx;
    begin
      in_span = (idx >= `BCV_IDX_WIN_BASE) && (idx <= `BCV_IDX_WIN_END);
    end
  endfunction

  // address phase accepted only while the bus is ready
  wire addr_valid = hsel && htrans[1] && hready;
  // word index from a byte address
  wire [9:0] addr_idx = haddr[11:2];
  // final wait cycle of a busy transfer
  wire last_cycle = st_q[1] && (cnt_q == ONE_WAIT);
  // register write lands on the answer edge
  wire do_wr = last_cycle && wr_q;
  // low index bits select the eeprom byte
  wire [6:0] ee_idx = idx_q[6:0];
  // eeprom enable bit
  wire ee_on = eeprom_ctrl_reg[`BCV_EE_ENABLE_BIT];

  // priority: power-up class, soft reset, power off, plain writes
  // power-up or hard switch
  wire cond_a = srst || hard_reset_switch;
  // switch without the enable bit is a hold, nothing to do
  // soft reset by bit or switch
  wire cond_b = (do_wr && idx_q == `BCV_IDX_RESET_CTRL && hwdata[`BCV_SOFT_RESET_BIT]) ||
                (reset_switch && reset_ctrl_reg[`BCV_SWITCH_SOFT_BIT]);
  // only a write that clears the power bit counts
  // power bit cleared
  wire cond_d = do_wr && idx_q == `BCV_IDX_POWER_CTRL && !hwdata[`BCV_POWER_BIT];

  // ==========================================
  // read mux
  reg [7:0] rd_byte;
  always @* begin
    // unmapped indices read zero
    rd_byte = 8'h00;
    if (idx_q == `BCV_IDX_LAMP) begin
      rd_byte = lamp_control;
    end else if (idx_q == `BCV_IDX_EE_CTRL) begin
      rd_byte = {7'h00, eeprom_ctrl_reg[`BCV_EE_ENABLE_BIT]};
    end else if (idx_q == `BCV_IDX_VOL_RIGHT) begin
      rd_byte = volume_right;
    end else if (idx_q == `BCV_IDX_VOL_LEFT) begin
      rd_byte = volume_left;
    end else if (idx_q == `BCV_IDX_RESET_CTRL) begin
      rd_byte = reset_ctrl_reg;
    end else if (idx_q == `BCV_IDX_POWER_CTRL) begin
      rd_byte = system_power_ctrl_one;
    end else if (idx_q == `BCV_IDX_FRONT_LIGHT) begin
      rd_byte = front_light_reg;
      // seconds and rtc state are visible for software checks
    end else if (idx_q == `BCV_IDX_SECONDS) begin
      rd_byte = seconds_counter;
    end else if (idx_q == `BCV_IDX_RTC_STATE) begin
      rd_byte = rtc_state_reg;
    end else if (in_window(idx_q)) begin
      // byte per location
      // disabled eeprom reads return the fill value
      rd_byte = ee_on ? ee_mem[ee_idx] : `BCV_FILL_VALUE;
    end else if (in_span(idx_q)) begin
      rd_byte = `BCV_FILL_VALUE;
    end
  end

  // ==========================================
  // eeprom array, no reset
  // undefined after reset
  // no reset so the array maps to plain storage
  // writes while the enable bit is low are lost
  always @(posedge sys_clk) begin
    // power-up class reset blocks a write landing at the same edge
    // write through window
    if (!cond_a && do_wr && in_window(idx_q) && ee_on) begin
      ee_mem[ee_idx] <= hwdata[7:0];
    end
  end

  // ==========================================
  // bus slave
  always @(posedge sys_clk) begin
    if (cond_a) begin
      st_q <= ST_IDLE;
      idx_q <= 10'h000;
      wr_q <= 1'b0;
      cnt_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (st_q)
        // idle: hreadyout high, one address phase taken
        ST_IDLE: begin
          if (addr_valid) begin
            st_q <= ST_BUSY;
            idx_q <= addr_idx;
            wr_q <= hwrite;
            hreadyout <= 1'b0;
            cnt_q <= in_window(addr_idx) ? EE_WAIT[7:0] : ONE_WAIT;
          end
        end

        // busy: answer on the final wait cycle
        ST_BUSY: begin
          if (last_cycle) begin
            st_q <= ST_IDLE;
            hreadyout <= 1'b1;
            // write answers carry zero; hrdata stands until the next answer
            hrdata <= wr_q ? 32'h0000_0000 : {24'h000000, rd_byte};
          end
          cnt_q <= cnt_q - 8'h01;
        end

        // illegal code: recover to idle
        default: begin
          st_q <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // time counter and rtc state
  always @(posedge sys_clk) begin
    if (cond_a) begin
      seconds_counter <= 8'h00;
      rtc_state_reg <= `BCV_RST_RTC_STATE;
    end else begin
      // wraps from 59 back to 0
      // counts through other resets
      if (sec_tick) begin
        seconds_counter <= (seconds_counter == `BCV_SECONDS_WRAP) ? 8'h00
                           : seconds_counter + 8'h01;
      end
      // status changes only by a bus write
      // rtc state holds on soft reset
      if (do_wr && idx_q == `BCV_IDX_RTC_STATE) begin
        rtc_state_reg <= hwdata[7:0];
      end
    end
  end

  // ==========================================
  // control registers
  always @(posedge sys_clk) begin
    if (cond_a) begin
      // every bank register to its initial value
      // enable starts cleared
      eeprom_ctrl_reg <= `BCV_RST_EE_CTRL;
      lamp_control <= `BCV_RST_LAMP;
      volume_right <= `BCV_RST_VOLUME;
      volume_left <= `BCV_RST_VOLUME;
      reset_ctrl_reg <= `BCV_RST_RESET_CTRL;
      system_power_ctrl_one <= `BCV_RST_POWER_CTRL;
      front_light_reg <= `BCV_RST_FRONT_LIGHT;
    end else if (cond_b) begin
      // rtc state and seconds counter are untouched here
      // soft reset reinit
      eeprom_ctrl_reg <= `BCV_RST_EE_CTRL;
      lamp_control <= `BCV_RST_LAMP;
      volume_right <= `BCV_RST_VOLUME;
      volume_left <= `BCV_RST_VOLUME;
      reset_ctrl_reg <= `BCV_RST_RESET_CTRL;
      system_power_ctrl_one <= `BCV_RST_POWER_CTRL;
      front_light_reg <= `BCV_RST_FRONT_LIGHT;
    end else if (cond_d) begin
      // volumes, eeprom and reset control take initial values
      // power off forced zero
      system_power_ctrl_one <= `BCV_OFF_VALUE;
      lamp_control <= `BCV_OFF_VALUE;
      front_light_reg <= `BCV_OFF_VALUE;
      eeprom_ctrl_reg <= `BCV_RST_EE_CTRL;
      volume_right <= `BCV_RST_VOLUME;
      volume_left <= `BCV_RST_VOLUME;
      reset_ctrl_reg <= `BCV_RST_RESET_CTRL;
    end else if (do_wr) begin
      // switch with soft reset enable clear changes nothing here
      if (idx_q == `BCV_IDX_LAMP) begin
        lamp_control <= hwdata[7:0];
      end else if (idx_q == `BCV_IDX_EE_CTRL) begin
        // upper bits forced to zero on write
        // only enable bit stored
        eeprom_ctrl_reg <= {7'h00, hwdata[`BCV_EE_ENABLE_BIT]};
      end else if (idx_q == `BCV_IDX_VOL_RIGHT) begin
        volume_right <= hwdata[7:0];
      end else if (idx_q == `BCV_IDX_VOL_LEFT) begin
        // left volume
        volume_left <= hwdata[7:0];
      end else if (idx_q == `BCV_IDX_RESET_CTRL) begin
        // bit0 is a strobe and is never stored
        reset_ctrl_reg <= {5'h00, hwdata[2:1], 1'b0};
      end else if (idx_q == `BCV_IDX_POWER_CTRL) begin
        // bit0 low here is caught as power off above
        system_power_ctrl_one <= hwdata[7:0];
      end else if (idx_q == `BCV_IDX_FRONT_LIGHT) begin
        // front light level
        front_light_reg <= hwdata[7:0];
      end
    end
  end

endmodule // bcv_regs

// [bcv_consts.vh]
// Purpose: constants for the board controller register bank
// Assumes: register index = byte address / 4 on the bus
// Notes: definitions only
`ifndef BCV_CONSTS_VH
`define BCV_CONSTS_VH

// ==========================================
// register indices
`define BCV_IDX_LAMP 10'h0a0
`define BCV_IDX_EE_CTRL 10'h0c0
`define BCV_IDX_VOL_RIGHT 10'h0d0
`define BCV_IDX_VOL_LEFT 10'h0d1
`define BCV_IDX_RESET_CTRL 10'h0e0
`define BCV_IDX_POWER_CTRL 10'h0e1
`define BCV_IDX_FRONT_LIGHT 10'h0e2
`define BCV_IDX_SECONDS 10'h0e3
`define BCV_IDX_RTC_STATE 10'h0e4
`define BCV_IDX_WIN_BASE 10'h100
`define BCV_IDX_WIN_END 10'h2ff

// ==========================================
// field positions
`define BCV_EE_ENABLE_BIT 0
`define BCV_SOFT_RESET_BIT 0
`define BCV_SWITCH_SOFT_BIT 1
`define BCV_SELECT_BIT 2
`define BCV_POWER_BIT 0

// ==========================================
// reset values
`define BCV_RST_LAMP 8'h00
`define BCV_RST_EE_CTRL 8'h00
`define BCV_RST_VOLUME 8'h00
`define BCV_RST_RESET_CTRL 8'h00
`define BCV_RST_POWER_CTRL 8'h01
`define BCV_RST_FRONT_LIGHT 8'h00
`define BCV_RST_RTC_STATE 8'h00
`define BCV_OFF_VALUE 8'h00
`define BCV_FILL_VALUE 8'hff

// ==========================================
// timing counts
`define BCV_EE_WAIT 4
`define BCV_SECONDS_WRAP 8'h3b

`endif

// [bcv_regs_assertions.sv]
// Purpose: timing and register checks on bcv_regs ports
// Assumes: one clock, srst synchronous
// Notes: bound to every bcv_regs
`timescale 1ns/1ns
module bcv_regs_assertions #(
  parameter EE_DEPTH = 128,
  parameter EE_WAIT = 4
) (
  input wire sys_clk,
  input wire srst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hard_reset_switch,
  input wire [7:0] lamp_control,
  input wire [7:0] volume_left,
  input wire [7:0] volume_right,
  input wire [7:0] front_light_reg,
  input wire [7:0] system_power_ctrl_one,
  input wire [7:0] eeprom_ctrl_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire take = hsel && htrans[1] && hready;
  wire [9:0] idx = haddr[11:2];
  wire win = idx >= 10'h100 && idx < 10'h180;
  // ====================
  // bus and register properties
  sequence s_wr(i);
    take && hwrite && idx == i;
  endsequence
  sequence s_answer;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_reg_wait:
    assert property (take && !win |=> s_answer) else $error("register answer late");
  chk_win_stall:
    assert property (take && win |=> !hreadyout ##(EE_WAIT-1) s_answer)
      else $error("window stall length");
  chk_lamp_write:
    assert property (s_wr(10'h0a0) |=> ##1 lamp_control == $past(hwdata[7:0]))
      else $error("lamp not written");
  chk_vol_left:
    assert property (s_wr(10'h0d1) |=> ##1 volume_left == $past(hwdata[7:0]))
      else $error("left volume not written");
  chk_hard_init:
    assert property (hard_reset_switch |=> lamp_control == 8'h00 && eeprom_ctrl_reg == 8'h00
      && system_power_ctrl_one == 8'h01) else $error("hard reset values");
  chk_vol_init:
    assert property (hard_reset_switch |=> volume_right == 8'h00 && volume_left == 8'h00)
      else $error("volume reset values");
  chk_ee_upper:
    assert property (eeprom_ctrl_reg[7:1] == 7'h00) else $error("eeprom ctrl upper bits");
  chk_power_off:
    assert property ($fell(system_power_ctrl_one[0]) |-> lamp_control == 8'h00
      && front_light_reg == 8'h00) else $error("power off values");
  chk_rd_upper:
    assert property (hreadyout |-> hrdata[31:8] == 24'h0) else $error("read upper bits");
endmodule // bcv_regs_assertions

bind bcv_regs bcv_regs_assertions #(.EE_DEPTH(EE_DEPTH), .EE_WAIT(EE_WAIT)) u_chk (.*);

// [bcv_host.sv]
// Purpose: host bus master model driving bcv_regs
// Assumes: single word transfers, one slave
// Notes: signals change only right after a rising edge
`timescale 1ns/1ns
module bcv_host (
  input wire sys_clk,
  output reg hsel,
  output reg [31:0] haddr,
  output reg [1:0] htrans,
  output reg hwrite,
  output reg [2:0] hsize,
  output reg [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ====================
  // one transfer; waits as long as the slave stalls
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge sys_clk);
      while (hready !== 1'b1)
        @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1)
        @(posedge sys_clk);
      q = hrdata;
    end
  endtask
endmodule // bcv_host

// [board_ctrl_eeprom_volume_led_regs_test.sv]
// Purpose: self-checking bench for bcv_regs
// Assumes: EE_WAIT 4, byte address is four times the index
// Notes: bus traffic goes through bcv_host
`timescale 1ns/1ns
module board_ctrl_eeprom_volume_led_regs_test;
  reg sys_clk = 0;
  reg srst = 1;
  reg hard_reset_switch = 0;
  reg reset_switch = 0;
  reg sec_tick = 0;
  wire hsel, hwrite, hready, hreadyout, hresp;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [7:0] lamp_control, volume_right, volume_left;
  wire [7:0] front_light_reg, system_power_ctrl_one, eeprom_ctrl_reg;
  integer errors = 0;
  integer n_tests = 0;
  integer cyc = 0;
  reg [31:0] r;
  assign hready = hreadyout;
  always #50 sys_clk = ~sys_clk;
  bcv_host host (.*);
  bcv_regs DUT (.*);
  // ====================
  // helpers
  task report_and_stop;
    begin
      $display("errors %0d tests %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("wrong value %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    host.xfer(1'b1, a, d, r);
  endtask
  task rd(input [31:0] a, input [31:0] e, input [8*10:1] nm);
    begin
      host.xfer(1'b0, a, 32'h0, r);
      chk(nm, e, r);
    end
  endtask
  task pulse_switch;
    begin
      reset_switch <= 1'b1;
      @(posedge sys_clk);
      reset_switch <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  // ====================
  // scenarios
  task t_regs;
    begin
      rd(32'h300, 32'h0, "ee_init");
      rd(32'h340, 32'h0, "vol_init");
      wr(32'h280, 32'ha5);
      wr(32'h340, 32'hff);
      wr(32'h344, 32'h3c);
      wr(32'h300, 32'hff);
      chk("lamp", 32'ha5, {24'h0, lamp_control});
      chk("vol_r_pin", 32'hff, {24'h0, volume_right});
      chk("vol_l_pin", 32'h3c, {24'h0, volume_left});
      chk("ee_pin", 32'h1, {24'h0, eeprom_ctrl_reg});
      rd(32'h340, 32'hff, "vol_r");
      rd(32'h344, 32'h3c, "vol_l");
      rd(32'h300, 32'h1, "ee_ctrl");
      rd(32'hffc, 32'h0, "unmapped");
      chk("hresp", 32'h0, {31'h0, hresp});
    end
  endtask
  task t_eeprom;
    begin
      wr(32'h300, 32'h0);
      wr(32'h400, 32'h11);
      rd(32'h400, 32'hff, "ee_off");
      wr(32'h300, 32'h1);
      wr(32'h400, 32'h5a);
      wr(32'h5fc, 32'hc3);
      rd(32'h400, 32'h5a, "ee_first");
      rd(32'h5fc, 32'hc3, "ee_last");
      wr(32'h600, 32'h77);
      rd(32'h600, 32'hff, "ee_beyond");
    end
  endtask
  task t_resets;
    begin
      repeat (3) begin
        sec_tick <= 1'b1;
        @(posedge sys_clk);
        sec_tick <= 1'b0;
        @(posedge sys_clk);
      end
      wr(32'h390, 32'h5a);
      wr(32'h280, 32'h3c);
      pulse_switch;
      chk("lamp_hold", 32'h3c, {24'h0, lamp_control});
      wr(32'h380, 32'h2);
      pulse_switch;
      chk("lamp_sw", 32'h0, {24'h0, lamp_control});
      rd(32'h390, 32'h5a, "rtc_keep");
      wr(32'h344, 32'h44);
      wr(32'h380, 32'h1);
      rd(32'h344, 32'h0, "vol_soft");
      rd(32'h38c, 32'h3, "sec_run");
      wr(32'h280, 32'hff);
      wr(32'h388, 32'h80);
      wr(32'h340, 32'h21);
      wr(32'h384, 32'h0);
      chk("lamp_off", 32'h0, {24'h0, lamp_control});
      chk("front_off", 32'h0, {24'h0, front_light_reg});
      chk("pwr_off", 32'h0, {24'h0, system_power_ctrl_one});
      rd(32'h340, 32'h0, "vol_off");
      rd(32'h390, 32'h5a, "rtc_off");
      hard_reset_switch <= 1'b1;
      @(posedge sys_clk);
      hard_reset_switch <= 1'b0;
      @(posedge sys_clk);
      rd(32'h38c, 32'h0, "sec_hard");
      rd(32'h384, 32'h1, "pwr_hard");
    end
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_eeprom;
    t_resets;
    report_and_stop;
  end
endmodule // board_ctrl_eeprom_volume_led_regs_test
